/* File: common/qpud_pkg.sv */
// shared constants for the quad pot up/down control link
package qpud_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned POS_W = 8;
    localparam int unsigned NUM_TAPS = 256;
    localparam int unsigned NUM_BANKS = 4;
    localparam logic [7:0] POS_MAX = 8'hFF;
    localparam logic [7:0] POS_MIN = 8'h00;
    localparam logic [7:0] STORED_RESET = 8'h80;
    // nonvolatile write time in microseconds
    localparam int unsigned NV_WRITE_US = 10000;
    localparam int unsigned NV_WRITE_CYC = NV_WRITE_US * (CLK_HZ / 1000000);
    // power-up recall time in microseconds
    localparam int unsigned RECALL_US = 2000;
    localparam int unsigned RECALL_CYC = RECALL_US * (CLK_HZ / 1000000);
    // wiper update latency, least 5 us
    localparam int unsigned UPDATE_MIN_US = 5;
    localparam int unsigned UPDATE_CYC = UPDATE_MIN_US * (CLK_HZ / 1000000);
    // host pin timing: setup, clock-high and end phases each held 2.5 us
    localparam int unsigned PHASE_NS = 2500;
    localparam int unsigned PHASE_CYC = (PHASE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // status register bit positions
    localparam int unsigned SR_NV_TARGET = 0;
    localparam int unsigned SR_BANK_LO = 1;
    localparam int unsigned SR_BANK_HI = 2;
    // host avalon register offsets (word index) and fields
    localparam logic [1:0] REG_CMD = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam int unsigned CMD_CH_LSB = 0;
    localparam int unsigned CMD_UP = 2;
    localparam int unsigned CMD_STORE = 3;
    localparam int unsigned CMD_STEPS_LSB = 8;
    localparam int unsigned CMD_GO = 31;
    localparam logic [31:0] AVS_UNMAPPED = 32'h00000000;
endpackage : qpud_pkg

/* File: common/qpud_if.sv */
// pin-level up/down interface between host and pot device
`timescale 1ns/1ps
interface qpud_if;
    logic chip_select_n;
    logic step_clk;
    logic step_up;
    logic channel_select_lo;
    logic channel_select_hi;
    logic write_protect_n;
    logic serial_busy_ignore;
    modport device (
        input chip_select_n, step_clk, step_up, channel_select_lo, channel_select_hi, write_protect_n,
        output serial_busy_ignore
    );
    modport host (
        output chip_select_n, step_clk, step_up, channel_select_lo, channel_select_hi, write_protect_n,
        input serial_busy_ignore
    );
endinterface : qpud_if

/* File: hdl/qpud_device.sv */
// quad potentiometer device: wiper registers, stored banks, up/down pin logic
`timescale 1ns/1ps

module qpud_device #(
    parameter int unsigned NV_CYC = qpud_pkg::NV_WRITE_CYC,
    parameter int unsigned RECALL_CYCLES = qpud_pkg::RECALL_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    qpud_if.device pins,
    input wire logic [2:0] status_bits,
    input wire logic [1:0] reg_channel,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic [qpud_pkg::NUM_CH*qpud_pkg::NUM_TAPS-1:0] tap_enable,
    output logic [31:0] wiper_positions,
    output logic store_busy,
    output logic ready
);
    typedef enum logic [3:0] {
        QPUD_RECALL = 4'b0001,
        QPUD_IDLE = 4'b0010,
        QPUD_STORE = 4'b0100,
        QPUD_SETTLE = 4'b1000
    } qpud_state_e;

    typedef struct packed {
        qpud_state_e state;
        logic [23:0] timer;
        logic [5:0] sync_cs;
        logic [5:0] sync_clk;
        logic [3:0] sync_up;
        logic [3:0] sync_lo;
        logic [3:0] sync_hi;
        logic [3:0] sync_wp;
        logic cs_last;
        logic clk_last;
        logic pend_valid;
        logic pend_up;
        logic [1:0] pend_ch;
        logic [1:0] store_ch;
        logic [3:0][7:0] wiper;
        logic [3:0][3:0][7:0] stored;
        logic [7:0] rdata;
        logic ignore_serial;
    } qpud_dev_s;

    qpud_dev_s r;
    qpud_dev_s next_r;
    logic cs_n_s;
    logic clk_s;
    logic up_s;
    logic wp_s;
    logic [1:0] ch_s;

    // bit [1] of each pair is the second flop; only it is read
    assign cs_n_s = r.sync_cs[1];
    assign clk_s = r.sync_clk[1];
    assign up_s = r.sync_up[1];
    assign wp_s = r.sync_wp[1];
    assign ch_s = {r.sync_hi[1], r.sync_lo[1]};

    always_comb begin
        next_r = r;
        next_r.sync_cs = {4'h0, r.sync_cs[0], pins.chip_select_n};
        next_r.sync_clk = {4'h0, r.sync_clk[0], pins.step_clk};
        next_r.sync_up = {2'h0, r.sync_up[0], pins.step_up};
        next_r.sync_lo = {2'h0, r.sync_lo[0], pins.channel_select_lo};
        next_r.sync_hi = {2'h0, r.sync_hi[0], pins.channel_select_hi};
        next_r.sync_wp = {2'h0, r.sync_wp[0], pins.write_protect_n};
        next_r.cs_last = cs_n_s;
        next_r.clk_last = clk_s;
        next_r.ignore_serial = ~cs_n_s;
        next_r.rdata = status_bits[qpud_pkg::SR_NV_TARGET] ? r.stored[reg_channel][status_bits[2:1]]
                                                           : r.wiper[reg_channel];
        case (r.state)
            QPUD_RECALL: begin
                if (r.timer >= 24'(RECALL_CYCLES - 1)) begin
                    for (int c = 0; c < qpud_pkg::NUM_CH; c++) begin
                        next_r.wiper[c] = r.stored[c][0];
                    end
                    next_r.timer = 24'h000000;
                    next_r.state = QPUD_IDLE;
                end else begin
                    next_r.timer = r.timer + 24'h000001;
                end
            end
            QPUD_IDLE: begin
                if (reg_write) begin
                    if (status_bits[qpud_pkg::SR_NV_TARGET]) begin
                        next_r.stored[reg_channel][status_bits[2:1]] = reg_wdata;
                    end else begin
                        next_r.wiper[reg_channel] = reg_wdata;
                    end
                end
                // falling edge while selected queues a step; direction sampled each edge
                if (!cs_n_s && r.clk_last && !clk_s) begin
                    next_r.pend_valid = 1'b1;
                    next_r.pend_up = up_s;
                    next_r.pend_ch = ch_s;
                    next_r.timer = 24'h000000;
                    next_r.state = QPUD_SETTLE;
                end else if (cs_n_s && !r.cs_last && clk_s && wp_s) begin
                    next_r.store_ch = ch_s;
                    next_r.timer = 24'h000000;
                    next_r.state = QPUD_STORE;
                end
                // select rising with clock low or protect low just returns to standby
            end
            QPUD_SETTLE: begin
                if (r.timer >= 24'(qpud_pkg::UPDATE_CYC - 1)) begin
                    if (r.pend_up && r.wiper[r.pend_ch] != qpud_pkg::POS_MAX) begin
                        next_r.wiper[r.pend_ch] = r.wiper[r.pend_ch] + 8'h01;
                    end else if (!r.pend_up && r.wiper[r.pend_ch] != qpud_pkg::POS_MIN) begin
                        next_r.wiper[r.pend_ch] = r.wiper[r.pend_ch] - 8'h01;
                    end
                    next_r.pend_valid = 1'b0;
                    next_r.state = QPUD_IDLE;
                end else begin
                    next_r.timer = r.timer + 24'h000001;
                end
            end
            QPUD_STORE: begin
                // pin activity is dropped for the whole write
                if (r.timer >= 24'(NV_CYC - 1)) begin
                    next_r.stored[r.store_ch][0] = r.wiper[r.store_ch];
                    next_r.timer = 24'h000000;
                    next_r.state = QPUD_IDLE;
                end else begin
                    next_r.timer = r.timer + 24'h000001;
                end
            end
            default: begin
                next_r.state = QPUD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
            r.state <= QPUD_RECALL;
            r.sync_cs <= 6'h3F;
            r.cs_last <= 1'b1;
            for (int c = 0; c < qpud_pkg::NUM_CH; c++) begin
                for (int b = 0; b < qpud_pkg::NUM_BANKS; b++) begin
                    r.stored[c][b] <= qpud_pkg::STORED_RESET;
                end
            end
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tap decode per channel, registered so exactly one bit is ever set
    genvar g;
    generate
        for (g = 0; g < qpud_pkg::NUM_CH; g++) begin : g_tap
            always_ff @(posedge clk) begin
                if (srst) begin
                    tap_enable[g*qpud_pkg::NUM_TAPS +: qpud_pkg::NUM_TAPS] <= 256'h1;
                end else if (clk_en) begin
                    // bit 0 sits at the low terminal
                    tap_enable[g*qpud_pkg::NUM_TAPS +: qpud_pkg::NUM_TAPS] <= 256'h1 << next_r.wiper[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            wiper_positions <= 32'h00000000;
            store_busy <= 1'b0;
            ready <= 1'b0;
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            wiper_positions <= next_r.wiper;
            store_busy <= (next_r.state == QPUD_STORE);
            ready <= (next_r.state != QPUD_RECALL);
            reg_rdata <= next_r.rdata;
        end
    end

    assign pins.serial_busy_ignore = r.ignore_serial;
endmodule : qpud_device

/* File: hdl/qpud_host.sv */
// host controller: avalon-mm command registers driving the up/down pins
`timescale 1ns/1ps
module qpud_host #(
    parameter int unsigned NV_CYC = qpud_pkg::NV_WRITE_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    qpud_if.host pins,
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    typedef enum logic [5:0] {
        QPH_IDLE = 6'b000001,
        QPH_SETUP = 6'b000010,
        QPH_HIGH = 6'b000100,
        QPH_LOW = 6'b001000,
        QPH_END = 6'b010000,
        QPH_WAIT = 6'b100000
    } qph_state_e;

    typedef struct packed {
        qph_state_e state;
        logic [23:0] timer;
        logic [7:0] steps;
        logic [1:0] ch;
        logic up;
        logic store;
        logic cs_n;
        logic sclk;
        logic [31:0] rdata;
        logic wait_n;
        logic done;
    } qph_s;

    qph_s r;
    qph_s next_r;
    logic phase_done;
    logic bus_req;

    assign phase_done = (r.timer >= 24'(qpud_pkg::PHASE_CYC - 1));
    assign bus_req = (avs_read || avs_write) && !r.wait_n;

    always_comb begin
        next_r = r;
        next_r.timer = r.timer + 24'h000001;
        next_r.wait_n = 1'b0;
        // every access answers one cycle after it is seen
        if (bus_req) begin
            next_r.wait_n = 1'b1;
            if (avs_read) begin
                next_r.rdata = (avs_address == qpud_pkg::REG_STATUS) ? {30'h0, r.done, r.state != QPH_IDLE}
                             : (avs_address == qpud_pkg::REG_CMD) ? {24'h0, r.steps}
                             : qpud_pkg::AVS_UNMAPPED;
            end
        end
        case (r.state)
            QPH_IDLE: begin
                next_r.cs_n = 1'b1;
                next_r.sclk = 1'b0;
                if (bus_req && avs_write && avs_address == qpud_pkg::REG_CMD
                    && avs_writedata[qpud_pkg::CMD_GO]) begin
                    next_r.ch = avs_writedata[qpud_pkg::CMD_CH_LSB +: 2];
                    next_r.up = avs_writedata[qpud_pkg::CMD_UP];
                    next_r.store = avs_writedata[qpud_pkg::CMD_STORE];
                    next_r.steps = avs_writedata[qpud_pkg::CMD_STEPS_LSB +: 8];
                    next_r.done = 1'b0;
                    next_r.cs_n = 1'b0;
                    next_r.timer = 24'h000000;
                    next_r.state = QPH_SETUP;
                end
            end
            QPH_SETUP: begin
                if (phase_done) begin
                    next_r.timer = 24'h000000;
                    next_r.state = (r.steps == 8'h00) ? QPH_END : QPH_HIGH;
                    next_r.sclk = (r.steps != 8'h00);
                end
            end
            QPH_HIGH: begin
                if (phase_done) begin
                    next_r.sclk = 1'b0; // falling edge steps the wiper
                    next_r.steps = r.steps - 8'h01;
                    next_r.timer = 24'h000000;
                    next_r.state = QPH_LOW;
                end
            end
            QPH_LOW: begin
                // wait covers the device's update latency before the next edge
                if (r.timer >= 24'(2 * qpud_pkg::UPDATE_CYC)) begin
                    next_r.timer = 24'h000000;
                    next_r.sclk = (r.steps != 8'h00) || r.store;
                    next_r.state = (r.steps == 8'h00) ? QPH_END : QPH_HIGH;
                end
            end
            QPH_END: begin
                if (phase_done) begin
                    next_r.cs_n = 1'b1;
                    next_r.timer = 24'h000000;
                    next_r.state = QPH_WAIT;
                end
            end
            QPH_WAIT: begin
                next_r.sclk = 1'b0;
                // after a store the full write time passes before the next access
                if (!r.store || r.timer >= 24'(NV_CYC + qpud_pkg::UPDATE_CYC)) begin
                    next_r.done = 1'b1;
                    next_r.state = QPH_IDLE;
                end
            end
            default: begin
                next_r.state = QPH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
            r.state <= QPH_IDLE;
            r.cs_n <= 1'b1;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    assign pins.chip_select_n = r.cs_n;
    assign pins.step_clk = r.sclk;
    assign pins.step_up = r.up; // held through the selection
    assign pins.channel_select_lo = r.ch[0];
    assign pins.channel_select_hi = r.ch[1];
    assign pins.write_protect_n = 1'b1;
    // bank bits are never driven here, so they stay at their zero default
    assign avs_readdata = r.rdata;
    assign avs_waitrequest = !r.wait_n;
endmodule : qpud_host

/* File: test/qpud_asserts.sv */
// concurrent checks on the up/down link and the device outputs
`timescale 1ns/1ps
module qpud_asserts #(
    parameter int unsigned NV_CYC = 50
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic chip_select_n,
    input wire logic step_clk,
    input wire logic write_protect_n,
    input wire logic serial_busy_ignore,
    input wire logic reg_write,
    input wire logic [qpud_pkg::NUM_CH*qpud_pkg::NUM_TAPS-1:0] tap_enable,
    input wire logic [31:0] wiper_positions,
    input wire logic store_busy,
    input wire logic ready
);
    int unsigned busy_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    // length of the running store, zero when idle
    always_ff @(posedge clk) begin
        if (srst || !store_busy) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end
    // a wiper may only hold or move one code, never wrap
    function automatic logic step_ok(input logic [3:0][7:0] a, input logic [3:0][7:0] b);
        logic ok;
        ok = 1'b1;
        for (int c = 0; c < 4; c++) begin
            ok &= (b[c] == a[c]) || (b[c] == a[c] + 8'h01 && a[c] != 8'hFF) || (b[c] == a[c] - 8'h01 && a[c] != 8'h00);
        end
        return ok;
    endfunction : step_ok
    ////////////////////////////////////////////////////////////////////////
    property p_one_tap; $onehot(tap_enable[255:0]) && $onehot(tap_enable[511:256])
        && $onehot(tap_enable[767:512]) && $onehot(tap_enable[1023:768]); endproperty
    a_one_tap: assert property (p_one_tap)
        else $error("tap count per channel not one");
    property p_tap_pos; tap_enable[wiper_positions[7:0]] && tap_enable[256 + wiper_positions[15:8]]
        && tap_enable[512 + wiper_positions[23:16]] && tap_enable[768 + wiper_positions[31:24]]; endproperty
    a_tap_pos: assert property (p_tap_pos)
        else $error("closed tap differs from wiper code");
    property p_sel_hi; (ready && !chip_select_n) [*4] |-> serial_busy_ignore; endproperty
    a_sel_hi: assert property (p_sel_hi)
        else $error("serial side not ignored while selected");
    property p_sel_lo; chip_select_n [*4] |-> !serial_busy_ignore; endproperty
    a_sel_lo: assert property (p_sel_lo)
        else $error("serial side ignored while deselected");
    property p_store_go; $rose(chip_select_n) && step_clk && write_protect_n && ready && !store_busy
        |-> ##[1:8] store_busy; endproperty
    a_store_go: assert property (p_store_go)
        else $error("store not started");
    property p_busy_max; store_busy |-> busy_cnt <= NV_CYC + 1; endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("store runs too long");
    property p_busy_min; $fell(store_busy) |-> busy_cnt >= NV_CYC - 1; endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("store ended too soon");
    property p_frozen; store_busy && $past(store_busy) && !reg_write && !$past(reg_write) && !$past(reg_write, 2)
        |-> $stable(wiper_positions); endproperty
    a_frozen: assert property (p_frozen)
        else $error("wiper moved during store");
    property p_step; $past(ready, 2) && !reg_write && !$past(reg_write) && !$past(reg_write, 2)
        |-> step_ok($past(wiper_positions), wiper_positions); endproperty
    a_step: assert property (p_step)
        else $error("wiper jumped or wrapped");
    property p_ready; $fell(srst) |-> ##[1:30] ready; endproperty
    a_ready: assert property (p_ready)
        else $error("recall not finished in time");
    c_store: cover property ($rose(store_busy));
    c_step: cover property (ready && $changed(wiper_positions));
    c_nostore: cover property ($rose(chip_select_n) && !step_clk);
endmodule : qpud_asserts

/* File: test/tb_quad_pot_updown_control.sv */
// bench: host and device over the up/down link, plus a device driven by hand
`timescale 1ns/1ps
module tb_quad_pot_updown_control;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic en = 1'b1;
    logic reg_write = 1'b0;
    logic [2:0] status_bits = 3'h0;
    logic [1:0] reg_channel = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [1:0] avs_address = 2'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cs_b = 1'b1;
    logic sclk_b = 1'b0;
    logic up_b = 1'b0;
    logic wp_b = 1'b1;
    logic [7:0] rd_a;
    logic [7:0] rd_b;
    logic [1023:0] taps;
    logic [31:0] wipers;
    logic [31:0] wipers_b;
    logic busy;
    logic busy_b;
    logic ready;
    logic ready_b;
    logic [3:0][7:0] exp_w;
    logic [31:0] q;
    logic [31:0] r;
    logic [7:0] mid;
    int seed;
    int cyc = 0;
    int bad_count = 0;
    int n_checks = 0;
    qpud_if bus_a();
    qpud_if bus_b();
    // second device is driven by hand so protect-low and standby cases can be reached
    assign bus_b.chip_select_n = cs_b;
    assign bus_b.step_clk = sclk_b;
    assign bus_b.step_up = up_b;
    assign bus_b.channel_select_lo = 1'b1;
    assign bus_b.channel_select_hi = 1'b0;
    assign bus_b.write_protect_n = wp_b;
    qpud_host #(.NV_CYC(50)) qpud_host_i (.clk(clk), .srst(srst), .clk_en(en), .pins(bus_a.host),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    qpud_device #(.NV_CYC(50), .RECALL_CYCLES(20)) qpud_device_i (.clk(clk), .srst(srst), .clk_en(en),
        .pins(bus_a.device), .status_bits(status_bits), .reg_channel(reg_channel), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_rdata(rd_a), .tap_enable(taps), .wiper_positions(wipers),
        .store_busy(busy), .ready(ready));
    qpud_device #(.NV_CYC(50), .RECALL_CYCLES(20)) qpud_device_b_i (.clk(clk), .srst(srst), .clk_en(en),
        .pins(bus_b.device), .status_bits(status_bits), .reg_channel(reg_channel), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_rdata(rd_b), .tap_enable(), .wiper_positions(wipers_b),
        .store_busy(busy_b), .ready(ready_b));
    qpud_asserts #(.NV_CYC(50)) qpud_asserts_i (.clk(clk), .srst(srst), .chip_select_n(bus_a.chip_select_n),
        .step_clk(bus_a.step_clk), .write_protect_n(bus_a.write_protect_n),
        .serial_busy_ignore(bus_a.serial_busy_ignore), .reg_write(reg_write), .tap_enable(taps),
        .wiper_positions(wipers), .store_busy(busy), .ready(ready));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            bad_count++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] sat(input logic [7:0] v, input logic up, input logic [7:0] n);
        for (int i = 0; i < n; i++) begin
            if (up && v != 8'hFF) v = v + 8'h01;
            else if (!up && v != 8'h00) v = v - 8'h01;
        end
        return v;
    endfunction : sat
    function automatic logic [1023:0] taps_of(input logic [3:0][7:0] w);
        logic [1023:0] t;
        t = '0;
        for (int c = 0; c < 4; c++) t[c * 256 + w[c]] = 1'b1;
        return t;
    endfunction : taps_of
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk(n < 50, "bus answer missing");
    endtask : av
    task automatic move(input logic [1:0] ch, input logic up, input logic [7:0] n, input logic st);
        status_bits <= 3'h0;
        av(1'b1, qpud_pkg::REG_CMD, {1'b1, 15'h0000, n, 4'h0, st, up, ch}, q);
        q = 32'h1;
        for (int k = 0; k < 2000 && q[0] !== 1'b0; k++) av(1'b0, qpud_pkg::REG_STATUS, 32'h0, q);
        repeat (140) @(posedge clk);
        for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk);
        exp_w[ch] = sat(exp_w[ch], up, n);
        chk(wipers === exp_w, "wiper after steps");
        chk(taps === taps_of(exp_w), "tap decode");
        status_bits <= 3'h1;
        reg_channel <= ch;
        repeat (3) @(posedge clk);
        if (st) chk(rd_a === exp_w[ch], "stored value");
    endtask : move
    task automatic pin_fall(input logic up, output logic [7:0] mid);
        up_b <= up;
        repeat (70) @(posedge clk);
        sclk_b <= 1'b1;
        repeat (70) @(posedge clk);
        sclk_b <= 1'b0;
        // sampled before the minimum update latency has run out
        repeat (110) @(posedge clk);
        mid = wipers_b[15:8];
        repeat (150) @(posedge clk);
    endtask : pin_fall
    task automatic wait_ready();
        for (int k = 0; k < 200 && ready !== 1'b1; k++) @(posedge clk);
        repeat (3) @(posedge clk);
        exp_w = {4{qpud_pkg::STORED_RESET}};
        chk(ready === 1'b1 && ready_b === 1'b1, "recall not done");
        chk(wipers === exp_w, "recall value");
        chk(taps === taps_of(exp_w), "tap after recall");
    endtask : wait_ready
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 77266;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        wait_ready();
        for (int b = 0; b < 4; b++) begin
            status_bits <= {b[1:0], 1'b1};
            reg_channel <= b[1:0];
            repeat (3) @(posedge clk);
            chk(rd_a === qpud_pkg::STORED_RESET, "bank read");
        end
        status_bits <= 3'h0;
        // end values first: saturation needs a preset near the rail
        for (int c = 0; c < 4; c++) begin
            // the previous move left the nonvolatile target selected
            status_bits <= 3'h0;
            reg_channel <= c[1:0];
            reg_wdata <= c[0] ? 8'h01 : 8'hFE;
            reg_write <= 1'b1;
            @(posedge clk);
            reg_write <= 1'b0;
            exp_w[c] = c[0] ? 8'h01 : 8'hFE;
            repeat (3) @(posedge clk);
            chk(wipers === exp_w, "direct write");
            move(c[1:0], !c[0], 8'h03, c == 2);
        end
        repeat (6) begin
            r = $random(seed);
            move(r[1:0], r[2], {6'h00, r[4:3]} + 8'h01, r[5]);
        end
        av(1'b1, 2'h3, 32'hFFFFFFFF, q);
        av(1'b0, 2'h2, 32'h0, q);
        chk(q === qpud_pkg::AVS_UNMAPPED, "unmapped read");
        // enable low must hold every register, a direct write included
        status_bits <= 3'h0;
        reg_channel <= 2'h0;
        reg_wdata <= ~exp_w[0];
        en <= 1'b0;
        reg_write <= 1'b1;
        repeat (4) @(posedge clk);
        reg_write <= 1'b0;
        chk(wipers === exp_w, "state moved while enable low");
        en <= 1'b1;
        repeat (3) @(posedge clk);
        chk(wipers === exp_w && taps === taps_of(exp_w), "state lost after enable");
        pin_fall(1'b1, mid);
        chk(wipers_b[15:8] === 8'h01, "moved in standby");
        cs_b <= 1'b0;
        pin_fall(1'b1, mid);
        chk(mid === 8'h01, "wiper changed before update latency");
        pin_fall(1'b1, mid);
        pin_fall(1'b0, mid);
        chk(wipers_b[15:8] === 8'h02, "up and down in one selection");
        sclk_b <= 1'b1;
        wp_b <= 1'b0;
        repeat (70) @(posedge clk);
        cs_b <= 1'b1;
        repeat (40) @(posedge clk);
        chk(busy_b === 1'b0, "store with protect low");
        sclk_b <= 1'b0;
        repeat (70) @(posedge clk);
        cs_b <= 1'b0;
        wp_b <= 1'b1;
        repeat (70) @(posedge clk);
        cs_b <= 1'b1;
        repeat (10) @(posedge clk);
        chk(busy_b === 1'b0, "store with clock low");
        cs_b <= 1'b0;
        sclk_b <= 1'b1;
        repeat (70) @(posedge clk);
        cs_b <= 1'b1;
        repeat (10) @(posedge clk);
        chk(busy_b === 1'b1, "store not running");
        // read back bank zero of the hand-driven channel
        reg_channel <= 2'h1;
        status_bits <= 3'h1;
        repeat (60) @(posedge clk);
        chk(busy_b === 1'b0 && rd_b === 8'h02, "store result");
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        wait_ready();
        wrap_up();
    end
endmodule : tb_quad_pot_updown_control
